// File: rtl/ddps_top.sv
// Power-up sequencer, unit select and cable status of a fixed disk drive.
`timescale 1ns/1ps
`default_nettype none
module ddps_top #(
  parameter int SPIN_CYC   = ddps_pkg::SPIN_LIMIT_CYC,
  parameter int SETTLE_CYC = ddps_pkg::SETTLE_CYC,
  parameter int CYL_LAST   = ddps_pkg::CYL_LAST
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire ddps_pkg::ddps_sense_s  sense,
  input  wire ddps_pkg::ddps_cable_s  cable,
  output logic                        stat_level,
  output ddps_pkg::ddps_stat_oe_s     stat_oe,
  input  wire logic                   read_bit,
  input  wire logic                   read_bit_stb,
  output logic                        rd_p,
  output logic                        rd_n,
  output var  logic                   spindle_pwr_en,
  output var  logic                   lock_release,
  output var  logic                   retract_cmd,
  output var  logic                   step_pulse,
  output var  logic                   step_inward,
  output var  logic [3:0]             head_num,
  output var  logic                   write_active,
  output logic                        irq
);
  import ddps_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  ddps_state_e          state_reg;
  ddps_state_e          state_next;
  logic [31:0]          spin_cnt_reg;
  logic [15:0]          recal_cnt_reg;
  logic [31:0]          settle_cnt_reg;
  logic [CYL_W-1:0]     cyl_reg;
  logic [CYL_W-1:0]     cyl_next;
  logic                 ready_reg;
  logic                 seek_done_reg;
  logic                 cyl0_reg;
  logic                 step_n_q_reg;
  logic [UNIT_W-1:0]    unit_reg;
  logic [IRQ_W-1:0]     irq_st_reg;
  logic [IRQ_W-1:0]     irq_en_reg;
  logic [IRQ_W-1:0]     irq_ev;
  logic [31:0]          rd_word;

  ////////////////////////////////////////////////////////////////////////////
  // Cylinder arithmetic shared by recalibration and host steps; it
  // saturates at both ends so a runaway step train cannot wrap.
  function automatic logic [CYL_W-1:0] cyl_move(
    input logic [CYL_W-1:0] cur,
    input logic             inward
  );
    logic [CYL_W-1:0] last;
    last = CYL_W'(CYL_LAST);
    if (inward)
      cyl_move = (cur == last) ? cur : cur + 1'b1;
    else
      cyl_move = (cur == '0) ? cur : cur - 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Supplies and unit select. The select line is low true, and the unit
  // address comes from the control register in place of a jumper.
  wire power_ok  = sense.supply5_ok & sense.supply12_ok;
  wire unit_sel  = ~cable.drive_sel_n[unit_reg];
  wire step_fall = step_n_q_reg & ~cable.step_n;
  wire host_step = step_fall & unit_sel;
  wire step_ok   = host_step & ready_reg;
  wire step_bad  = host_step & ~ready_reg;
  wire dir_in    = ~cable.dir_in_n;
  wire settled   = settle_cnt_reg == 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state. A supply loss from any state parks the heads.
  wire spin_out  = spin_cnt_reg == 32'(SPIN_CYC - 1);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_PARKED: begin
        if (power_ok)
          state_next = ST_SPINUP;
      end
      ST_SPINUP: begin
        if (!power_ok)
          state_next = ST_PARKED;
        else if (sense.speed_full)
          state_next = ST_RECAL;
        else if (spin_out && !sense.speed_min_ok)
          state_next = ST_FAILED;
      end
      ST_RECAL: begin
        if (!power_ok)
          state_next = ST_PARKED;
        else if (sense.track0_sense)
          state_next = ST_READY;
      end
      ST_READY: begin
        if (!power_ok)
          state_next = ST_PARKED;
      end
      ST_FAILED: begin
        // Only a supply cycle leaves the shutdown.
        if (!power_ok)
          state_next = ST_PARKED;
      end
      default: state_next = ST_PARKED;
    endcase
  end

  // The state register itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      state_reg <= ST_PARKED;
    else
      state_reg <= state_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Spin-up timeout counter, running only while the spindle comes up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      spin_cnt_reg <= 32'h0;
    else if (state_reg != ST_SPINUP)
      spin_cnt_reg <= 32'h0;
    else if (!spin_out)
      spin_cnt_reg <= spin_cnt_reg + 32'h1;
  end

  // Recalibration step pacing: one outward step per interval until the
  // track zero sense comes true.
  wire recal_tick = (state_reg == ST_RECAL) &&
                    (recal_cnt_reg == 16'(RECAL_STEP_CYC - 1));
  wire recal_step = recal_tick & ~sense.track0_sense;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      recal_cnt_reg <= 16'h0;
    else if (state_reg != ST_RECAL || recal_tick)
      recal_cnt_reg <= 16'h0;
    else
      recal_cnt_reg <= recal_cnt_reg + 16'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cylinder position. Recalibration forces zero on completion; host steps
  // count only once ready, so steps during recalibration leave the cylinder unchanged.
  always_comb begin
    cyl_next = cyl_reg;
    if (state_next == ST_READY && state_reg == ST_RECAL)
      cyl_next = '0;
    else if (recal_step)
      cyl_next = cyl_move(cyl_reg, 1'b0);
    else if (step_ok)
      cyl_next = cyl_move(cyl_reg, dir_in);
  end

  // Position register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cyl_reg <= '0;
    else
      cyl_reg <= cyl_next;
  end

  // Settle timer, reloaded by every accepted step so a buffered train of
  // steps keeps seek-done low until the last one has settled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      settle_cnt_reg <= 32'h0;
    else if (state_next != ST_READY)
      settle_cnt_reg <= 32'h0;
    else if (step_ok)
      settle_cnt_reg <= 32'(SETTLE_CYC);
    else if (!settled)
      settle_cnt_reg <= settle_cnt_reg - 32'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags. All three come from state_next in one cycle, so at the
  // end of recalibration they rise on the same edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg     <= 1'b0;
      seek_done_reg <= 1'b0;
      cyl0_reg      <= 1'b0;
    end else begin
      ready_reg     <= state_next == ST_READY;
      seek_done_reg <= (state_next == ST_READY) && !step_ok &&
                       (settle_cnt_reg <= 32'h1);
      cyl0_reg      <= (state_next == ST_READY) &&
                       (cyl_next == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mechanism outputs. The latch stays engaged until the spindle is at
  // speed again; retraction is held for as long as the heads are parked.
  // A step that meets a supply loss is dropped, as the latch is closing.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spindle_pwr_en <= 1'b0;
      lock_release   <= 1'b0;
      retract_cmd    <= 1'b1;
      step_pulse     <= 1'b0;
      step_inward    <= 1'b0;
    end else begin
      spindle_pwr_en <= sense.supply12_ok &&
                        (state_next == ST_SPINUP ||
                         state_next == ST_RECAL ||
                         state_next == ST_READY);
      lock_release   <= state_next == ST_RECAL ||
                        state_next == ST_READY;
      retract_cmd    <= state_next == ST_PARKED;
      step_pulse     <= (recal_step | step_ok) &
                        power_ok;
      step_inward    <= step_ok & dir_in &
                        power_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Head number and write enable, taken only by the selected unit. The
  // lines are low true, so an open cable reads as head 0 and reading.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_num     <= 4'h0;
      write_active <= 1'b0;
      step_n_q_reg <= 1'b1;
    end else begin
      step_n_q_reg <= cable.step_n;
      if (unit_sel)
        head_num <= ~cable.head_sel_n;
      write_active <= unit_sel & ready_reg & seek_done_reg &
                      ~cable.write_gate_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Open-collector status lines: the level is always low and only the
  // selected unit ever pulls them.
  assign stat_level             = 1'b0;
  assign stat_oe.ready_oe_n     = ~(unit_sel & ready_reg);
  assign stat_oe.seek_done_oe_n = ~(unit_sel & seek_done_reg);
  assign stat_oe.cyl0_oe_n      = ~(unit_sel & cyl0_reg);
  assign stat_oe.wfault_oe_n    = ~(unit_sel & sense.wfault_sense);
  assign stat_oe.index_oe_n     = ~(unit_sel & sense.index_sense);

  ////////////////////////////////////////////////////////////////////////////
  // Read stream. It is muted while writing or not ready, since the read
  // channel then carries nothing the controller should decode.
  ddps_mfm_enc #(
    .HALF_CYC (MFM_HALF_CYC)
  ) u_mfm (
    .pclk    (pclk),
    .presetn (presetn),
    .bit_stb (read_bit_stb),
    .bit_in  (read_bit),
    .enable  (ready_reg & ~write_active),
    .rd_p    (rd_p),
    .rd_n    (rd_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events and sticky status; a new event beats a clear.
  assign irq_ev[IRQ_READY]    = (state_reg == ST_RECAL) &&
                                (state_next == ST_READY);
  assign irq_ev[IRQ_SPINFAIL] = (state_reg == ST_SPINUP) &&
                                (state_next == ST_FAILED);
  assign irq_ev[IRQ_PWRLOSS]  = (state_reg != ST_PARKED) &&
                                (state_next == ST_PARKED);
  assign irq_ev[IRQ_REFUSED]  = step_bad;
  assign irq = |(irq_st_reg & irq_en_reg);

  ////////////////////////////////////////////////////////////////////////////
  // APB decode. Zero wait states; an unknown offset answers with pslverr.
  wire acc      = psel & penable;
  wire wr_acc   = acc & pwrite;
  wire hit_ctrl = paddr == OFS_CTRL;
  wire hit_stat = paddr == OFS_STATUS;
  wire hit_ist  = paddr == OFS_IRQ_ST;
  wire hit_iclr = paddr == OFS_IRQ_CLR;
  wire hit_ien  = paddr == OFS_IRQ_EN;
  wire hit_any  = hit_ctrl | hit_stat | hit_ist | hit_iclr | hit_ien;
  wire [IRQ_W-1:0] clr_bits = (wr_acc & hit_iclr) ?
                              pwdata[IRQ_W-1:0] : '0;
  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  // Read mux; the clear register is write-only and reads as zero.
  always_comb begin
    rd_word = 32'h0;
    if (hit_ctrl)
      rd_word[UNIT_W-1:0] = unit_reg;
    else if (hit_stat) begin
      rd_word[ST_STATE_LSB +: 3]     = state_reg;
      rd_word[ST_CYL_LSB +: CYL_W]   = cyl_reg;
      rd_word[ST_HEAD_LSB +: 4]      = head_num;
      rd_word[ST_WRITE_BIT]          = write_active;
      rd_word[ST_SEL_BIT]            = unit_sel;
      rd_word[ST_SEEKD_BIT]          = seek_done_reg;
    end else if (hit_ist)
      rd_word[IRQ_W-1:0] = irq_st_reg;
    else if (hit_ien)
      rd_word[IRQ_W-1:0] = irq_en_reg;
  end

  // Read data is captured in the setup cycle and stands in the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata <= rd_word;
  end

  // Writable registers and sticky interrupt status.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_reg   <= CTRL_RST;
      irq_en_reg <= IRQ_EN_RST;
      irq_st_reg <= '0;
    end else begin
      if (wr_acc && hit_ctrl)
        unit_reg <= pwdata[UNIT_W-1:0];
      if (wr_acc && hit_ien)
        irq_en_reg <= pwdata[IRQ_W-1:0];
      irq_st_reg <= (irq_st_reg & ~clr_bits) | irq_ev;
    end
  end

endmodule // ddps_top
`default_nettype wire

// File: rtl/ddps_pkg.sv
// Constants, register map and types of the drive power-up and select block.
package ddps_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Timing, taken from the 40 MHz pclk.
  localparam int CLK_HZ          = 40_000_000;
  localparam int SPIN_LIMIT_S    = 10;
  localparam int SPIN_LIMIT_CYC  = SPIN_LIMIT_S * CLK_HZ;
  localparam int RECAL_STEP_NS   = 3000;
  localparam int RECAL_STEP_CYC  = (RECAL_STEP_NS * (CLK_HZ / 1_000_000)
                                    + 999) / 1000;
  localparam int SETTLE_MS       = 5;
  localparam int SETTLE_CYC      = SETTLE_MS * (CLK_HZ / 1000);
  localparam int MFM_HALF_CYC    = 4;

  //////////////////////////////////////////////////////////////////////////
  // Geometry.
  localparam int CYL_W           = 10;
  localparam int CYL_LAST        = 917;
  localparam int UNIT_W          = 2;

  //////////////////////////////////////////////////////////////////////////
  // Register byte offsets and fields.
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST  = 8'h08;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h0c;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h10;
  localparam logic [UNIT_W-1:0] CTRL_RST = 2'h0;
  localparam int ST_STATE_LSB    = 0;
  localparam int ST_CYL_LSB      = 4;
  localparam int ST_HEAD_LSB     = 16;
  localparam int ST_WRITE_BIT    = 20;
  localparam int ST_SEL_BIT      = 21;
  localparam int ST_SEEKD_BIT    = 22;
  localparam int IRQ_READY       = 0;
  localparam int IRQ_SPINFAIL    = 1;
  localparam int IRQ_PWRLOSS     = 2;
  localparam int IRQ_REFUSED     = 3;
  localparam int IRQ_W           = 4;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;

  //////////////////////////////////////////////////////////////////////////
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_PARKED,
    ST_SPINUP,
    ST_RECAL,
    ST_READY,
    ST_FAILED
  } ddps_state_e;

  // Cable inputs, all active low as they arrive.
  typedef struct packed {
    logic [3:0] drive_sel_n;
    logic [3:0] head_sel_n;
    logic       write_gate_n;
    logic       step_n;
    logic       dir_in_n;
  } ddps_cable_s;

  // Open-collector enables, low while the line is pulled low.
  typedef struct packed {
    logic ready_oe_n;
    logic seek_done_oe_n;
    logic cyl0_oe_n;
    logic wfault_oe_n;
    logic index_oe_n;
  } ddps_stat_oe_s;

  // Supply and mechanism sense inputs, active high.
  typedef struct packed {
    logic supply5_ok;
    logic supply12_ok;
    logic speed_min_ok;
    logic speed_full;
    logic track0_sense;
    logic index_sense;
    logic wfault_sense;
  } ddps_sense_s;

endpackage

// File: rtl/ddps_mfm_enc.sv
// MFM encoder that drives recovered read bits onto a differential pair.
`timescale 1ns/1ps
`default_nettype none
module ddps_mfm_enc #(
  parameter int HALF_CYC = ddps_pkg::MFM_HALF_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic bit_stb,
  input  wire logic bit_in,
  input  wire logic enable,
  output var  logic rd_p,
  output var  logic rd_n
);
  import ddps_pkg::*;

  logic [7:0] half_cnt_reg;
  logic       prev_reg;
  logic       second_reg;
  logic       pulse_reg;
  logic       data_bit_reg;
  wire        clock_bit = ~prev_reg & ~bit_in;
  wire        half_end  = half_cnt_reg == 8'(HALF_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // A clock half-cell goes out first, the data half-cell after it. A
  // strobe that comes before the cell ends restarts the cell.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_reg <= 8'h00;
      prev_reg     <= 1'b0;
      second_reg   <= 1'b0;
      pulse_reg    <= 1'b0;
      data_bit_reg <= 1'b0;
    end else if (enable && bit_stb) begin
      prev_reg     <= bit_in;
      data_bit_reg <= bit_in;
      pulse_reg    <= clock_bit;
      second_reg   <= 1'b1;
      half_cnt_reg <= 8'h00;
    end else if (half_end) begin
      pulse_reg    <= second_reg & data_bit_reg & enable;
      second_reg   <= 1'b0;
      half_cnt_reg <= 8'h00;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h01;
    end
  end

  // The pair is kept complementary from reset onward.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_p <= 1'b0;
      rd_n <= 1'b1;
    end else begin
      rd_p <= pulse_reg;
      rd_n <= ~pulse_reg;
    end
  end

endmodule // ddps_mfm_enc
`default_nettype wire

// File: verification/ddps_checker.sv
// Concurrent checks on the sequencer and cable side of the drive block.
`timescale 1ns/1ps
`default_nettype none
module ddps_checker #(
  parameter int SPIN_CYC = 200
) (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire ddps_pkg::ddps_sense_s   sense,
  input wire ddps_pkg::ddps_cable_s   cable,
  input wire logic                    stat_level,
  input wire ddps_pkg::ddps_stat_oe_s stat_oe,
  input wire logic                    rd_p,
  input wire logic                    rd_n,
  input wire logic                    spindle_pwr_en,
  input wire logic                    lock_release,
  input wire logic                    retract_cmd,
  input wire logic                    step_pulse,
  input wire logic                    step_inward,
  input wire logic [3:0]              head_num,
  input wire logic                    write_active
);
  import ddps_pkg::*;
  int spin_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  //////////////////////////////////////////////////////////////////////////
  // Powered cycles below minimum speed; bounds the shutdown delay.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) spin_cnt <= 0;
    else if (spindle_pwr_en && !sense.speed_min_ok) spin_cnt <= spin_cnt + 1;
    else spin_cnt <= 0;
  end
  sequence s_supply_loss;
    !(sense.supply5_ok && sense.supply12_ok);
  endsequence
  sequence s_parked;
    retract_cmd && !lock_release && !spindle_pwr_en;
  endsequence
  sequence s_host_step;
    $fell(cable.step_n) && !stat_oe.ready_oe_n;
  endsequence
  //////////////////////////////////////////////////////////////////////////
  a_loss_retract: assert property (s_supply_loss |=> s_parked)
    else $error("Actuator not parked after supply loss.");
  a_ready_trio: assert property (($fell(stat_oe.ready_oe_n) &&
    $stable(cable.drive_sel_n)) |->
    !stat_oe.seek_done_oe_n && !stat_oe.cyl0_oe_n)
    else $error("Ready came without seek done and cylinder zero.");
  a_host_step: assert property (s_host_step |-> ##[1:2] step_pulse)
    else $error("Host step not carried out.");
  a_step_unlocked: assert property (step_pulse |-> lock_release)
    else $error("Step issued while the actuator is latched.");
  a_step_dir: assert property (step_inward |-> step_pulse)
    else $error("Inward flag without a step.");
  a_spin_limit: assert property (spin_cnt <= SPIN_CYC + 2)
    else $error("Spindle left powered past the spin-up limit.");
  a_write_gate: assert property (write_active ==
    (!$past(cable.write_gate_n) && !$past(stat_oe.ready_oe_n) &&
    !$past(stat_oe.seek_done_oe_n)))
    else $error("Write state disagrees with gate and readiness.");
  a_head_latch: assert property (!$past(stat_oe.ready_oe_n) |->
    head_num == ~$past(cable.head_sel_n))
    else $error("Head number does not follow the select lines.");
  a_unsel_quiet: assert property (cable.drive_sel_n == 4'hf |->
    stat_oe == 5'h1f)
    else $error("Status driven with no unit selected.");
  a_level_low: assert property (stat_level == 1'b0)
    else $error("Status lines not pulled low when asserted.");
  a_rd_pair: assert property (rd_p != rd_n)
    else $error("Read data pair not complementary.");
endmodule // ddps_checker
`default_nettype wire

// File: verification/ddps_mech_model.sv
// Spindle, actuator and cable pull-up model facing the drive block.
`timescale 1ns/1ps
`default_nettype none
module ddps_mech_model #(
  parameter int LAND_POS = 6
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    supply_on,
  input  wire logic                    spin_ok,
  input  wire logic                    spindle_pwr_en,
  input  wire logic                    retract_cmd,
  input  wire logic                    step_pulse,
  input  wire logic                    step_inward,
  input  wire ddps_pkg::ddps_stat_oe_s stat_oe,
  input  wire logic                    stat_level,
  output var  ddps_pkg::ddps_sense_s   sense,
  output var  logic [4:0]              lines_n,
  output var  logic [9:0]              pos
);
  import ddps_pkg::*;
  logic [4:0] speed_reg;
  // Speed ramps only while powered and spin_ok is high, so a stalled spindle never turns.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_reg <= 5'h00;
      pos       <= 10'(LAND_POS);
    end else begin
      if (!spindle_pwr_en) speed_reg <= 5'h00;
      else if (spin_ok && speed_reg != 5'h1f) speed_reg <= speed_reg + 5'h01;
      if (retract_cmd) pos <= 10'(LAND_POS);
      else if (step_pulse && step_inward) pos <= pos + 10'h001;
      else if (step_pulse && pos != 10'h000) pos <= pos - 10'h001;
    end
  end
  // Index shows at top speed; a short landing zone keeps recal brief.
  assign sense = {supply_on, supply_on, speed_reg >= 5'h08,
                  speed_reg >= 5'h10, pos == 10'h000, &speed_reg, 1'b0};
  // Terminated open-collector lines read high unless pulled low.
  assign lines_n = stat_oe | {5{stat_level}};
endmodule // ddps_mech_model
`default_nettype wire

// File: verification/disk_drive_powerup_and_select_tb.sv
// Self-checking bench for the drive power-up and select block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module disk_drive_powerup_and_select_tb;
  import ddps_pkg::*;
  localparam int SPIN   = 200;
  localparam int SETTLE = 20;
  logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic          stat_level, read_bit, read_bit_stb, rd_p, rd_n, irq;
  logic          spindle_pwr_en, lock_release, retract_cmd, step_pulse;
  logic          step_inward, write_active, supply_on, spin_ok, rerr, rd_q;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rdat;
  logic [3:0]    head_num;
  logic [4:0]    lines_n;
  logic [9:0]    mpos;
  ddps_sense_s   sense;
  ddps_cable_s   cable;
  ddps_stat_oe_s stat_oe;
  int            error_cnt, tests_run, steps, rises, snap;
  ddps_top #(.SPIN_CYC(SPIN), .SETTLE_CYC(SETTLE), .CYL_LAST(917)) i_dut (.*);
  ddps_mech_model i_mech (
    .pclk(pclk), .presetn(presetn), .supply_on(supply_on),
    .spin_ok(spin_ok), .spindle_pwr_en(spindle_pwr_en),
    .retract_cmd(retract_cmd), .step_pulse(step_pulse),
    .step_inward(step_inward), .stat_oe(stat_oe), .stat_level(stat_level),
    .sense(sense), .lines_n(lines_n), .pos(mpos));
  //////////////////////////////////////////////////////////////////////////
  // Free-running clock and event counters for steps and read pulses.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (step_pulse === 1'b1) steps <= steps + 1;
    if (rd_p === 1'b1 && rd_q === 1'b0) rises <= rises + 1;
    rd_q <= rd_p;
  end
  // One APB transfer; read data and error are taken at the pready edge.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // Direction is set well ahead of the falling step edge and held after.
  task step(input logic inward);
    cable.dir_in_n <= !inward;
    repeat (2) @(posedge pclk);
    cable.step_n <= 1'b0;
    repeat (3) @(posedge pclk);
    cable.step_n <= 1'b1;
    repeat (3) @(posedge pclk);
  endtask
  task wait_ready;
    for (int i = 0; i < 3000 && lines_n[4] !== 1'b0; i++) @(posedge pclk);
    `CHK(lines_n[4], 1'b0)
  endtask
  task stop_test;
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog, far beyond the few thousand cycles the run needs.
  initial begin
    #(25 * 20000);
    error_cnt++;
    stop_test;
  end
  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, refusal, power-up, seeks, select, power faults.
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; presetn = 1'b0; cable = '1; read_bit = 1'b0;
    read_bit_stb = 1'b0; supply_on = 1'b0; spin_ok = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(({retract_cmd, lock_release, spindle_pwr_en, irq}), 4'h8)
    `CHK(lines_n, 5'h1f)
    rd(OFS_CTRL);
    `CHK(rdat, 32'h0)
    rd(8'h14);
    `CHK(({rerr, rdat}), 33'h100000000)
    apb(1'b1, OFS_CTRL, 32'h2);
    rd(OFS_CTRL);
    `CHK(rdat, 32'h2)
    cable.drive_sel_n <= 4'hb; // Only one select line low.
    step(1'b1);
    `CHK(steps, 0)
    rd(OFS_IRQ_ST);
    `CHK(rdat, 32'h8)
    `CHK(irq, 1'b0)
    apb(1'b1, OFS_IRQ_EN, 32'hf);
    rd(OFS_IRQ_EN);
    `CHK(({rdat, irq}), 33'h1f)
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    @(posedge pclk);
    `CHK(irq, 1'b0)
    supply_on <= 1'b1;
    for (int i = 0; i < 500 && lock_release !== 1'b1; i++) @(posedge pclk);
    step(1'b0);
    wait_ready;
    `CHK(steps, 6)
    `CHK(lines_n, 5'h02)
    `CHK(({lock_release, retract_cmd}), 2'h2)
    rd(OFS_STATUS);
    `CHK(({rdat[13:4], rdat[2:0]}), 13'h3)
    rd(OFS_IRQ_ST);
    `CHK(({rdat, irq}), 33'h13)
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    repeat (3) step(1'b1);
    `CHK(lines_n[3], 1'b1)
    step(1'b0);
    repeat (SETTLE + 4) @(posedge pclk);
    `CHK(lines_n, 5'h06)
    rd(OFS_STATUS);
    `CHK(({rdat[13:4], mpos}), 20'h00802)
    for (int h = 0; h < 16; h++) begin
      cable.head_sel_n <= ~4'(h);
      repeat (2) @(posedge pclk);
      `CHK(head_num, 4'(h))
    end
    cable.head_sel_n <= 4'hf;
    repeat (2) @(posedge pclk);
    `CHK(head_num, 4'h0)
    cable.write_gate_n <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(OFS_STATUS);
    `CHK(({write_active, rdat[20]}), 2'h3)
    cable.write_gate_n <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK(write_active, 1'b0)
    snap = rises;
    for (int i = 3; i >= 0; i--) begin
      read_bit     <= 4'b1001 >> i;
      read_bit_stb <= 1'b1;
      @(posedge pclk);
      read_bit_stb <= 1'b0;
      repeat (7) @(posedge pclk);
    end
    repeat (10) @(posedge pclk);
    `CHK(rises - snap, 3)
    cable.drive_sel_n <= 4'hd;
    repeat (2) @(posedge pclk);
    `CHK(lines_n, 5'h1f)
    snap = steps;
    step(1'b1);
    `CHK(steps, snap)
    cable.drive_sel_n <= 4'hb;
    supply_on <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK(({retract_cmd, lock_release, spindle_pwr_en}), 3'h4)
    rd(OFS_IRQ_ST);
    `CHK(rdat[3:0], 4'h4)
    supply_on <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHK(lock_release, 1'b0)
    wait_ready;
    `CHK(mpos, 10'h000)
    supply_on <= 1'b0;
    spin_ok   <= 1'b0;
    repeat (3) @(posedge pclk);
    supply_on <= 1'b1;
    repeat (SPIN + 20) @(posedge pclk);
    `CHK(spindle_pwr_en, 1'b0)
    rd(OFS_STATUS);
    `CHK(rdat[2:0], 3'h4)
    rd(OFS_IRQ_ST);
    `CHK(rdat[1], 1'b1)
    spin_ok <= 1'b1;
    repeat (300) @(posedge pclk);
    `CHK(({lines_n[4], spindle_pwr_en}), 2'h2)
    stop_test;
  end
endmodule // disk_drive_powerup_and_select_tb
bind ddps_top ddps_checker #(.SPIN_CYC(SPIN_CYC)) i_chk (.*);
`default_nettype wire
